//--- rtl/smbus_clock_buffer_config.v
`timescale 1ns/100ps
`include "smbus_clock_buffer_map.vh"
// Functional notes
// - device acknowledges its address with write direction after start
// - index byte acknowledged and used as first byte location
// - in writes, the byte count is acknowledged
// - data bytes stored at consecutive locations, each acknowledged
// - read sets index, then repeated start and read address acknowledged
// - first returned byte in a read is the byte count
// - then bytes from consecutive locations starting at index
// - returned count byte is the index 7 return count field, bytes continue until host nack
// - byte 0 holds enables for outputs 0 to 7, default 1
// - cleared enable overrides pin, output parks in stop state
// - byte 1 bit 5 enables output 8, default 1
// - byte 1 bits 1:0 select swing, default 10
// - byte 2 bit i selects edge rate of output i, default fast
// - byte 3 bit 0 selects edge rate of output 8, others reserved
// - index 4 always reads all ones
// - byte 5 read-only revision and maker codes
// - byte 6 read-only class and part number codes
// - stop state field selects parked levels of both pins
// - return count in low five bits of index 7, default eight
// - serial interface active only while input clock runs
// - output starts or stops 1 to 3 output clocks after enable pin
module smbus_clock_buffer_config #(
   parameter [3:0] REVISION_CODE = 4'h1, // arbitrary value
   parameter [3:0] MAKER_CODE    = 4'h5, // arbitrary value
   parameter [1:0] CLASS_CODE    = 2'h2, // arbitrary value
   parameter [5:0] PART_CODE     = 6'h15, // arbitrary value
   parameter [6:0] BASE_ADDRESS  = 7'h40, // arbitrary value
   parameter       OUTPUTS       = 9,
   parameter       LATENCY       = 2
) (
   // clock and reset
   input  wire               i_sys_clk,
   input  wire               i_rst_n,
   // bus pins
   input  wire               i_scl,
   input  wire               i_sda,
   output reg                o_sda_out,
   output reg                o_sda_oe,
   // address strap
   input  wire [1:0]         i_bus_address_strap,
   // differential input clock and output enable pins (active low)
   input  wire               i_ref_clk,
   input  wire [OUTPUTS-1:0] i_output_enable_n,
   // outputs
   output reg  [OUTPUTS-1:0] o_clock_pair_output_run,
   output reg  [OUTPUTS-1:0] o_clock_pair_true_level,
   output reg  [OUTPUTS-1:0] o_clock_pair_comp_level,
   output reg  [OUTPUTS-1:0] o_clock_pair_drive_en,
   output reg  [OUTPUTS-1:0] o_edge_rate_select,
   output reg  [1:0]         o_swing_select
);

   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_RACK  = 3'h2;
   localparam ST_TX    = 3'h3;
   localparam ST_TACK  = 3'h4;
   localparam ST_SKIP  = 3'h5;

   // synchronisers
   reg [1:0] scl_meta, sda_meta, ref_meta;
   reg [OUTPUTS-1:0] oe_meta, oe_sync;
   reg       scl_s, sda_s, ref_s, scl_d, sda_d, ref_d;
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_meta <= 2'h3;
         sda_meta <= 2'h3;
         ref_meta <= 2'h0;
         oe_meta  <= {OUTPUTS{1'b1}};
         oe_sync  <= {OUTPUTS{1'b1}};
         scl_s <= 1'b1;
         sda_s <= 1'b1;
         ref_s <= 1'b0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         ref_d <= 1'b0;
      end else begin
         scl_meta <= {scl_meta[0], i_scl};
         sda_meta <= {sda_meta[0], i_sda};
         ref_meta <= {ref_meta[0], i_ref_clk};
         oe_meta  <= i_output_enable_n;
         oe_sync  <= oe_meta;
         scl_s <= scl_meta[1];
         sda_s <= sda_meta[1];
         ref_s <= ref_meta[1];
         scl_d <= scl_s;
         sda_d <= sda_s;
         ref_d <= ref_s;
      end
   end

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_cnd = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_cnd  = scl_s & scl_d & ~sda_d & sda_s;
   wire ref_edge  = ref_s & ~ref_d;

   // input clock activity watchdog
   reg [7:0] ref_idle;
   reg       ref_running;
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_idle    <= 8'h00;
         ref_running <= 1'b0;
      end else if (ref_edge) begin
         ref_idle    <= 8'h00;
         ref_running <= 1'b1;
      end else if (ref_idle == `INPUT_CLOCK_TIMEOUT) begin
         ref_running <= 1'b0;
      end else begin
         ref_idle <= ref_idle + 8'h01;
      end
   end

   // strap synchronised, then caught once after reset release
   reg       strap_taken;
   reg [1:0] strap_meta, strap_sync, strap_age;
   reg [1:0] strap;
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         strap_taken <= 1'b0;
         strap_meta  <= 2'h0;
         strap_sync  <= 2'h0;
         strap_age   <= 2'h0;
         strap       <= 2'h0;
      end else begin
         strap_meta <= i_bus_address_strap;
         strap_sync <= strap_meta;
         if (!strap_taken) begin
            if (strap_age == 2'h2) begin
               strap_taken <= 1'b1;
               strap       <= strap_sync;
            end else begin
               strap_age <= strap_age + 2'h1;
            end
         end
      end
   end
   wire [6:0] my_address = BASE_ADDRESS + {5'h00, strap};

   // configuration bytes
   reg [7:0] enable_low, enable8_swing, rate_low, rate8;
   reg [4:0] return_count;
   reg [1:0] stop_state;

   // serial engine
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shift;
   reg [1:0] phase;
   reg [7:0] index;
   reg [7:0] remain;
   reg       reading, sent_count, host_nack;
   reg [7:0] rd_byte;

   always @* begin
      case (index)
         `IDX_OUTPUT_ENABLE_LOW_GROUP:  rd_byte = enable_low;
         `IDX_OUTPUT8_ENABLE_AND_SWING: rd_byte = enable8_swing;
         `IDX_EDGE_RATE_LOW_GROUP:      rd_byte = rate_low;
         `IDX_EDGE_RATE_OUTPUT8:        rd_byte = rate8;
         `IDX_RESERVED_ALL_ONES:        rd_byte = `RST_RESERVED_ALL_ONES;
         `IDX_REVISION_AND_MAKER_CODE:  rd_byte = {REVISION_CODE, MAKER_CODE};
         `IDX_PART_CLASS_AND_IDENTITY:  rd_byte = {CLASS_CODE, PART_CODE};
         `IDX_RETURN_COUNT:             rd_byte = {3'h0, return_count};
         `IDX_STOP_STATE:               rd_byte = {6'h00, stop_state};
         default:                       rd_byte = 8'h00;
      endcase
   end

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         phase <= 2'h0;
         index <= 8'h00;
         remain <= 8'h00;
         reading <= 1'b0;
         sent_count <= 1'b0;
         host_nack <= 1'b0;
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
         enable_low <= `RST_OUTPUT_ENABLE_LOW_GROUP;
         enable8_swing <= `RST_OUTPUT8_ENABLE_AND_SWING;
         rate_low <= `RST_EDGE_RATE_LOW_GROUP;
         rate8 <= `RST_EDGE_RATE_OUTPUT8;
         return_count <= `RST_RETURN_COUNT;
         stop_state <= `RST_STOP_STATE;
      end else if (!ref_running) begin
         state <= ST_IDLE;
         o_sda_oe <= 1'b0;
      end else if (stop_cnd) begin
         state <= ST_IDLE;
         o_sda_oe <= 1'b0;
      end else if (start_cnd) begin
         state <= ST_ADDR;
         bit_cnt <= 4'h0;
         o_sda_oe <= 1'b0;
      end else begin
         case (state)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  if (shift[7:1] == my_address) begin
                     o_sda_oe <= 1'b1;
                     reading <= shift[0];
                     sent_count <= 1'b0;
                     remain <= {3'h0, return_count};
                     phase <= shift[0] ? 2'h3 : 2'h0;
                     state <= ST_RACK;
                  end else begin
                     state <= ST_SKIP;
                  end
               end
            end
            ST_RACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (reading) begin
                     state <= ST_TX;
                     shift <= sent_count ? rd_byte : {3'h0, return_count};
                     o_sda_oe <= ~(sent_count ? rd_byte[7] : 1'b0);
                     if (sent_count) begin
                        index <= index + 8'h01;
                     end
                     sent_count <= 1'b1;
                  end else begin
                     o_sda_oe <= 1'b0;
                     state <= ST_TX;
                  end
               end
            end
            ST_TX: begin
               if (!reading) begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     state <= ST_RACK;
                     o_sda_oe <= 1'b1;
                     if (phase == 2'h0) begin
                        index <= shift;
                        phase <= 2'h1;
                     end else if (phase == 2'h1) begin
                        remain <= shift;
                        phase <= 2'h2;
                     end else if (remain != 8'h00) begin
                        remain <= remain - 8'h01;
                        index <= index + 8'h01;
                        case (index)
                           `IDX_OUTPUT_ENABLE_LOW_GROUP:  enable_low <= shift;
                           `IDX_OUTPUT8_ENABLE_AND_SWING: enable8_swing <= {2'h0, shift[5], 2'h0, 1'b1, shift[1:0]};
                           `IDX_EDGE_RATE_LOW_GROUP:      rate_low <= shift;
                           `IDX_EDGE_RATE_OUTPUT8:        rate8 <= {rate8[7:1], shift[0]};
                           `IDX_RETURN_COUNT:             return_count <= shift[4:0];
                           `IDX_STOP_STATE:               stop_state <= shift[1:0];
                           default:                       index <= index + 8'h01;
                        endcase
                     end
                  end
               end else begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h7) begin
                        o_sda_oe <= 1'b0;
                        state <= ST_TACK;
                     end else begin
                        o_sda_oe <= ~shift[6];
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  host_nack <= sda_s;
               end else if (scl_fall) begin
                  if (host_nack) begin
                     state <= ST_SKIP;
                  end else begin
                     // next byte must be on the pin as the acknowledge bit ends
                     state <= ST_TX;
                     bit_cnt <= 4'h0;
                     shift <= rd_byte;
                     o_sda_oe <= ~rd_byte[7];
                     index <= index + 8'h01;
                  end
               end
            end
            ST_SKIP: begin
               o_sda_oe <= 1'b0;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // output control
   reg  [OUTPUTS-1:0] enable_bits;
   always @* begin
      enable_bits = {enable8_swing[`OUTPUT8_ENABLE_BIT], enable_low};
   end

   wire [OUTPUTS-1:0] gate_run, gate_true, gate_comp, gate_en;
   genvar g;
   generate
      for (g = 0; g < OUTPUTS; g = g + 1) begin : gen_out
         output_gate #(
            .LATENCY        (LATENCY)
         ) u_gate (
            .i_sys_clk      (i_sys_clk),
            .i_rst_n        (i_rst_n),
            .i_out_clk_edge (ref_edge),
            .i_run_request  (enable_bits[g] & ~oe_sync[g]),
            .i_stop_state   (stop_state),
            .o_run          (gate_run[g]),
            .o_true_level   (gate_true[g]),
            .o_comp_level   (gate_comp[g]),
            .o_drive_en     (gate_en[g])
         );
      end
   endgenerate

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_clock_pair_output_run  <= {OUTPUTS{1'b0}};
         o_clock_pair_true_level  <= {OUTPUTS{1'b0}};
         o_clock_pair_comp_level  <= {OUTPUTS{1'b0}};
         o_clock_pair_drive_en    <= {OUTPUTS{1'b1}};
         o_edge_rate_select       <= {OUTPUTS{1'b1}};
         o_swing_select           <= 2'h2;
      end else begin
         o_clock_pair_output_run  <= gate_run;
         o_clock_pair_true_level  <= gate_true;
         o_clock_pair_comp_level  <= gate_comp;
         o_clock_pair_drive_en    <= gate_en;
         o_edge_rate_select       <= {rate8[`OUTPUT8_EDGE_RATE_BIT], rate_low};
         o_swing_select           <= enable8_swing[`SWING_MSB:0];
      end
   end

endmodule // smbus_clock_buffer_config

//--- rtl/smbus_clock_buffer_map.vh
`ifndef SMBUS_CLOCK_BUFFER_MAP_VH
`define SMBUS_CLOCK_BUFFER_MAP_VH
// configuration byte indices
`define IDX_OUTPUT_ENABLE_LOW_GROUP   8'h00
`define IDX_OUTPUT8_ENABLE_AND_SWING  8'h01
`define IDX_EDGE_RATE_LOW_GROUP       8'h02
`define IDX_EDGE_RATE_OUTPUT8         8'h03
`define IDX_RESERVED_ALL_ONES         8'h04
`define IDX_REVISION_AND_MAKER_CODE   8'h05
`define IDX_PART_CLASS_AND_IDENTITY   8'h06
`define IDX_RETURN_COUNT              8'h07
`define IDX_STOP_STATE                8'h0b
// field positions
`define OUTPUT8_ENABLE_BIT            5
`define SWING_MSB                     1
`define OUTPUT8_EDGE_RATE_BIT         0
`define RETURN_COUNT_MSB              4
// reset values
`define RST_OUTPUT_ENABLE_LOW_GROUP   8'hff
`define RST_OUTPUT8_ENABLE_AND_SWING  8'h26
`define RST_EDGE_RATE_LOW_GROUP       8'hff
`define RST_EDGE_RATE_OUTPUT8         8'hcd
`define RST_RESERVED_ALL_ONES         8'hff
`define RST_RETURN_COUNT              5'h08
`define RST_STOP_STATE                2'h0
// stop states
`define STOP_LOW_LOW                  2'h0
`define STOP_HIZ_HIZ                  2'h1
`define STOP_HIGH_LOW                 2'h2
`define STOP_LOW_HIGH                 2'h3
// timing
`define ENABLE_LATENCY_MIN            1
`define ENABLE_LATENCY_MAX            3
`define INPUT_CLOCK_TIMEOUT           8'h40
`endif

//--- rtl/output_gate.v
`timescale 1ns/100ps
`include "smbus_clock_buffer_map.vh"
// per-output enable resolution and parked level drive
module output_gate #(
   parameter LATENCY = 2
) (
   // clock and reset
   input  wire       i_sys_clk,
   input  wire       i_rst_n,
   // control
   input  wire       i_out_clk_edge,
   input  wire       i_run_request,
   input  wire [1:0] i_stop_state,
   // drive
   output reg        o_run,
   output reg        o_true_level,
   output reg        o_comp_level,
   output reg        o_drive_en
);

   reg [1:0] pending;

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pending      <= 2'h0;
         o_run        <= 1'b0;
         o_true_level <= 1'b0;
         o_comp_level <= 1'b0;
         o_drive_en   <= 1'b1;
      end else begin
         if (i_run_request == o_run) begin
            pending <= 2'h0;
         end else if (i_out_clk_edge) begin
            if (pending == LATENCY[1:0] - 2'h1) begin
               o_run   <= i_run_request;
               pending <= 2'h0;
            end else begin
               pending <= pending + 2'h1;
            end
         end
         o_drive_en <= (i_stop_state != `STOP_HIZ_HIZ);
         o_true_level <= (i_stop_state == `STOP_HIGH_LOW);
         o_comp_level <= (i_stop_state == `STOP_LOW_HIGH);
      end
   end

endmodule // output_gate

//--- dv/smbus_clock_buffer_config_props.sv
`timescale 1ns/100ps
module smbus_clock_buffer_config_props #(
   parameter OUTPUTS = 9
) (
   // clock and reset
   input wire               i_sys_clk,
   input wire               i_rst_n,
   // bus and pins
   input wire               i_scl,
   input wire               i_sda,
   input wire               o_sda_out,
   input wire               o_sda_oe,
   input wire [1:0]         i_bus_address_strap,
   input wire               i_ref_clk,
   input wire [OUTPUTS-1:0] i_output_enable_n,
   // outputs
   input wire [OUTPUTS-1:0] o_clock_pair_output_run,
   input wire [OUTPUTS-1:0] o_clock_pair_true_level,
   input wire [OUTPUTS-1:0] o_clock_pair_comp_level,
   input wire [OUTPUTS-1:0] o_clock_pair_drive_en,
   input wire [OUTPUTS-1:0] o_edge_rate_select,
   input wire [1:0]         o_swing_select
);
   logic       ref_q;
   logic [7:0] ref_idle;
   logic [7:0] bus_idle;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // cycles since the input clock last moved, and since the bus went quiet
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_q    <= 1'b0;
         ref_idle <= 8'h00;
         bus_idle <= 8'h00;
      end else begin
         ref_q    <= i_ref_clk;
         ref_idle <= (i_ref_clk != ref_q) ? 8'h00 : (ref_idle == 8'hff) ? ref_idle : ref_idle + 8'h01;
         bus_idle <= !(i_scl && i_sda) ? 8'h00 : (bus_idle == 8'hff) ? bus_idle : bus_idle + 8'h01;
      end
   end
   drive_zero_a: assert property (o_sda_out == 1'b0) else $error("data pin driven high");
   ack_rise_low_a: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("drive began with clock high");
   ack_fall_low_a: assert property ($fell(o_sda_oe) |-> !i_scl) else $error("drive ended with clock high");
   oe_stable_high_a: assert property (i_scl && $past(i_scl, 4) |-> $stable(o_sda_oe))
      else $error("data changed while clock high");
   ref_quiet_a: assert property (ref_idle > 8'd150 |-> !o_sda_oe) else $error("bus answered without clock");
   stop1_latency_a: assert property ($rose(i_output_enable_n[1]) && o_clock_pair_output_run[1]
      |-> o_clock_pair_output_run[1] [*2] ##[1:40] !o_clock_pair_output_run[1]) else $error("output 1 stop late");
   stop8_latency_a: assert property ($rose(i_output_enable_n[8])
      |-> ##[1:40] !o_clock_pair_output_run[8]) else $error("output 8 stop late");
   parked_level_a: assert property (!o_clock_pair_output_run[0] && o_clock_pair_drive_en[0]
      |-> !(o_clock_pair_true_level[0] && o_clock_pair_comp_level[0])) else $error("parked levels both high");
   idle_config_a: assert property (bus_idle > 8'd60
      |-> $stable(o_swing_select) && $stable(o_edge_rate_select)) else $error("setting changed on idle bus");
endmodule // smbus_clock_buffer_config_props

bind smbus_clock_buffer_config smbus_clock_buffer_config_props #(.OUTPUTS(OUTPUTS)) u_props (
   .i_sys_clk, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_bus_address_strap, .i_ref_clk,
   .i_output_enable_n, .o_clock_pair_output_run, .o_clock_pair_true_level, .o_clock_pair_comp_level,
   .o_clock_pair_drive_en, .o_edge_rate_select, .o_swing_select);

//--- dv/smbus_host_model.sv
`timescale 1ns/100ps
module smbus_host_model (
   // bus pins
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda_oe
);
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end
   // data falls while clock high, 500 kHz bus clock
   task send_start;
      begin
         #250 o_sda_oe = 1'b0;
         #750 o_scl = 1'b1;
         #500 o_sda_oe = 1'b1;
         #500 o_scl = 1'b0;
      end
   endtask
   task send_stop;
      begin
         #250 o_sda_oe = 1'b1;
         #750 o_scl = 1'b1;
         #500 o_sda_oe = 1'b0;
         #500;
      end
   endtask
   task xfer_bit(input logic low, output logic seen);
      begin
         #250 o_sda_oe = low;
         #750 o_scl = 1'b1;
         #500 seen = i_sda;
         #500 o_scl = 1'b0;
      end
   endtask
   task put_byte(input logic [7:0] b, output logic ack);
      logic s;
      int   i;
      begin
         for (i = 7; i >= 0; i--) xfer_bit(~b[i], s);
         xfer_bit(1'b0, s);
         ack = ~s;
      end
   endtask
   task get_byte(input logic last, output logic [7:0] b);
      logic s;
      int   i;
      begin
         for (i = 7; i >= 0; i--) begin
            xfer_bit(1'b0, s);
            b[i] = s;
         end
         xfer_bit(~last, s);
      end
   endtask
endmodule // smbus_host_model

//--- dv/smbus_clock_buffer_config_tb.sv
`timescale 1ns/100ps
module smbus_clock_buffer_config_tb;
   localparam [3:0] REV  = 4'h3;  // arbitrary value
   localparam [3:0] MKR  = 4'h9;  // arbitrary value
   localparam [1:0] CLS  = 2'h1;  // arbitrary value
   localparam [5:0] PART = 6'h2a; // arbitrary value
   localparam [6:0] ADDR = 7'h41;
   logic       i_sys_clk           = 1'b0;
   logic       i_rst_n             = 1'b0;
   logic       i_ref_clk           = 1'b0;
   logic       ref_run             = 1'b1;
   logic [8:0] i_output_enable_n   = 9'h000;
   logic [1:0] i_bus_address_strap = 2'h1;
   wire        host_oe;
   wire        i_scl;
   wire        i_sda;
   wire        o_sda_out;
   wire        o_sda_oe;
   wire  [8:0] o_clock_pair_output_run;
   wire  [8:0] o_clock_pair_true_level;
   wire  [8:0] o_clock_pair_comp_level;
   wire  [8:0] o_clock_pair_drive_en;
   wire  [8:0] o_edge_rate_select;
   wire  [1:0] o_swing_select;
   int         mismatches = 0;
   int         cmp_count  = 0;
   logic [7:0] wbuf [0:7];
   logic [7:0] rbuf [0:7];
   logic [7:0] exp  [0:7];
   // open-drain data line with pull-up
   assign i_sda = (host_oe | o_sda_oe) ? 1'b0 : 1'b1;
   always #25 i_sys_clk = ~i_sys_clk;
   always #200 if (ref_run) i_ref_clk = ~i_ref_clk;
   smbus_clock_buffer_config #(.REVISION_CODE(REV), .MAKER_CODE(MKR), .CLASS_CODE(CLS), .PART_CODE(PART)) dut (
      .i_sys_clk, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe, .i_bus_address_strap, .i_ref_clk,
      .i_output_enable_n, .o_clock_pair_output_run, .o_clock_pair_true_level, .o_clock_pair_comp_level,
      .o_clock_pair_drive_en, .o_edge_rate_select, .o_swing_select);
   smbus_host_model host (.i_sda(i_sda), .o_scl(i_scl), .o_sda_oe(host_oe));
   task chk(input logic [8:0] seen, input logic [8:0] want);
      begin
         cmp_count++;
         if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
         end
      end
   endtask
   task waitc(input int n);
      begin
         repeat (n) @(posedge i_sys_clk);
         #1;
      end
   endtask
   task open_frame(input logic [7:0] idx);
      logic a;
      begin
         host.send_start();
         host.put_byte({ADDR, 1'b0}, a);
         chk(9'(a), 9'h1);
         host.put_byte(idx, a);
         chk(9'(a), 9'h1);
      end
   endtask
   task wr_block(input logic [7:0] idx, input logic [7:0] n);
      logic a;
      int   i;
      begin
         open_frame(idx);
         host.put_byte(n, a);
         chk(9'(a), 9'h1);
         for (i = 0; i < n; i++) begin
            host.put_byte(wbuf[i], a);
            chk(9'(a), 9'h1);
         end
         host.send_stop();
      end
   endtask
   task rd_block(input logic [7:0] idx, input logic [7:0] cnt);
      logic       a;
      logic [7:0] b;
      int         i;
      begin
         open_frame(idx);
         host.send_start();
         host.put_byte({ADDR, 1'b1}, a);
         chk(9'(a), 9'h1);
         host.get_byte(1'b0, b);
         chk(9'(b), 9'(cnt));
         for (i = 0; i < cnt; i++) host.get_byte(i == cnt - 1, rbuf[i]);
         host.send_stop();
         for (i = 0; i < cnt; i++) chk(9'(rbuf[i]), 9'(exp[i]));
      end
   endtask
   task probe(input logic [6:0] adr, input logic want);
      logic a;
      begin
         host.send_start();
         host.put_byte({adr, 1'b0}, a);
         host.send_stop();
         chk(9'(a), 9'(want));
      end
   endtask
   task test_defaults;
      begin
         exp = '{8'hff, 8'h26, 8'hff, 8'hcd, 8'hff, {REV, MKR}, {CLS, PART}, 8'h08};
         rd_block(8'h00, 8'd8);
         chk(o_edge_rate_select, 9'h1ff);
         chk(9'(o_swing_select), 9'h2);
         $display("defaults test done");
      end
   endtask
   task test_write;
      begin
         wbuf = '{8'h00, 8'h5a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
         wr_block(8'h01, 8'd6);
         exp = '{8'h04, 8'h5a, 8'hcc, 8'hff, {REV, MKR}, {CLS, PART}, 8'h08, 8'h00};
         rd_block(8'h01, 8'd8);
         waitc(40);
         chk(o_edge_rate_select, 9'h05a);
         chk(9'({o_swing_select, o_clock_pair_output_run[8]}), 9'h0);
         wbuf[0] = 8'h03;
         wr_block(8'h07, 8'd1);
         exp = '{8'h5a, 8'hcc, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
         rd_block(8'h02, 8'd3);
         $display("write test done");
      end
   endtask
   task test_park;
      int s;
      begin
         wbuf[0] = 8'hfe;
         wr_block(8'h00, 8'd1);
         for (s = 0; s < 4; s++) begin
            wbuf[0] = 8'(s);
            wr_block(8'h0b, 8'd1);
            wbuf[0] = 8'h20 | 8'(s);
            wr_block(8'h01, 8'd1);
            waitc(40);
            chk(9'({o_clock_pair_output_run[0], o_clock_pair_drive_en[0], o_clock_pair_true_level[0] &
               o_clock_pair_drive_en[0], o_clock_pair_comp_level[0] & o_clock_pair_drive_en[0]}),
               9'({1'b0, s != 1, s == 2, s == 3}));
            chk(9'({o_swing_select, o_clock_pair_output_run[8]}), 9'({s[1:0], 1'b1}));
         end
         i_output_enable_n = 9'h102;
         waitc(40);
         chk(9'({o_clock_pair_output_run[1], o_clock_pair_output_run[8], o_clock_pair_true_level[1],
            o_clock_pair_comp_level[1]}), 9'h1);
         i_output_enable_n = 9'h000;
         waitc(40);
         chk(9'({o_clock_pair_output_run[1], o_clock_pair_output_run[8]}), 9'h3);
         $display("park test done");
      end
   endtask
   task test_probe;
      begin
         probe(ADDR + 7'h1, 1'b0);
         ref_run = 1'b0;
         waitc(150);
         probe(ADDR, 1'b0);
         ref_run = 1'b1;
         waitc(80);
         probe(ADDR, 1'b1);
         $display("address test done");
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      waitc(40);
      test_defaults();
      test_write();
      test_park();
      test_probe();
      final_report();
   end
   initial begin
      #3000000;
      mismatches++;
      final_report();
   end
endmodule // smbus_clock_buffer_config_tb
